//--- inc/ucop_defines.svh
// constants for the cell output port
`ifndef UCOP_DEFINES_SVH
`define UCOP_DEFINES_SVH
`define UCOP_DATA_W 16
`define UCOP_ADDR_W 5
`define UCOP_IDX_W 6
`define UCOP_BUF_DEPTH 64
`define UCOP_CELL_WORDS16 6'h1B
`define UCOP_CELL_BYTES8 6'h35
`define UCOP_RST_WORD 16'h0000
`define UCOP_RST_HS 1'b1
`define UCOP_LINK_DIV 2
`endif

//--- inc/ucop_pkg.sv
// types for the cell output port
package ucop_pkg;
    typedef enum logic [1:0] {
        UCOP_IDLE = 2'h0,
        UCOP_SEND = 2'h1
    } ucop_state_t;

    typedef struct packed {
        logic phy_mode;
        logic level2;
        logic width8;
        logic clk_internal;
        logic [4:0] my_addr;
    } ucop_cfg_t;

    typedef struct packed {
        logic lclk;
        logic hs;
        logic [4:0] addr;
    } ucop_pins_t;

    typedef struct packed {
        logic [15:0] word;
        logic par;
        logic soc;
        logic bus_oe;
        logic hs;
        logic hs_oe;
        logic lclk;
        logic lclk_oe;
    } ucop_out_t;
endpackage

//--- src/ucop_cell_buf.sv
// one-cell store between the user side and the link side
`timescale 1ns/1ps
`include "ucop_defines.svh"
module ucop_cell_buf #(
    parameter int W = `UCOP_DATA_W,
    parameter int DEPTH = `UCOP_BUF_DEPTH,
    parameter int IDX_W = `UCOP_IDX_W
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_user_word,
    input wire logic i_user_valid,
    output logic o_user_ready,
    input wire logic [IDX_W-1:0] i_cell_len,
    output logic o_cell_ready,
    input wire logic [IDX_W-1:0] i_rd_idx,
    output logic [W-1:0] o_rd_word,
    input wire logic i_release
);
    typedef struct packed {
        logic [IDX_W-1:0] cnt;
        logic full;
        logic rdy;
    } ucop_buf_st_t;

    logic [W-1:0] mem [DEPTH];
    ucop_buf_st_t q, d;
    logic wr;

    assign wr = i_user_valid && !q.full;

    always_comb begin
        d = q;
        if (wr) begin
            if (q.cnt == i_cell_len - 1'b1) begin
                d.cnt = '0;
                d.full = 1'b1;
            end else begin
                d.cnt = q.cnt + 1'b1;
            end
        end
        if (i_release && q.full) begin
            d.full = 1'b0;
        end
        d.rdy = !d.full;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q <= '0;
            q.rdy <= 1'b1;
        end else begin
            q <= d;
        end
        if (wr) begin
            mem[q.cnt] <= i_user_word;
        end
    end

    assign o_user_ready = q.rdy;
    assign o_cell_ready = q.full;
    assign o_rd_word = mem[i_rd_idx];
endmodule

//--- src/ucop_top.sv
// cell output port: link clock, handshake and word bus driver
`timescale 1ns/1ps
`include "ucop_defines.svh"
module ucop_top #(
    parameter int IDX_W = `UCOP_IDX_W,
    parameter int DEPTH = `UCOP_BUF_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire ucop_pkg::ucop_cfg_t i_cfg,
    input wire logic [15:0] i_user_word,
    input wire logic i_user_valid,
    output logic o_user_ready,
    input wire logic i_cell_out_link_clock,
    output logic o_cell_out_link_clock,
    output logic o_cell_out_link_clock_oe,
    input wire logic [4:0] i_cell_out_phy_address,
    input wire logic i_cell_out_handshake_in,
    output logic o_cell_out_handshake_out,
    output logic o_cell_out_handshake_out_oe,
    output logic [15:0] o_cell_out_word_bus,
    output logic o_cell_out_word_bus_oe,
    output logic o_cell_out_parity,
    output logic o_cell_out_parity_oe,
    output logic o_cell_out_start_marker,
    output logic o_cell_out_start_marker_oe
);
    typedef struct packed {
        ucop_pkg::ucop_pins_t s1;
        ucop_pkg::ucop_pins_t s2;
        logic lclk_p;
        logic div;
        ucop_pkg::ucop_state_t st;
        logic [IDX_W-1:0] idx;
        logic sel;
        ucop_pkg::ucop_out_t out;
        logic [1:0] warm;
    } ucop_st_t;

    ucop_st_t q, d;
    ucop_pkg::ucop_pins_t pins;
    logic [15:0] rd_word;
    logic [IDX_W-1:0] cell_len;
    logic cell_ready;
    logic rel;
    logic tick;
    logic match;

    function automatic ucop_pkg::ucop_out_t put_word(input ucop_pkg::ucop_out_t o,
            input logic [15:0] w, input logic w8, input logic first);
        ucop_pkg::ucop_out_t r;
        r = o;
        r.word = w8 ? {8'h00, w[7:0]} : w;
        r.par = ~^r.word;
        r.soc = first;
        r.bus_oe = 1'b1;
        return r;
    endfunction

    assign pins = '{lclk: i_cell_out_link_clock, hs: i_cell_out_handshake_in,
                    addr: i_cell_out_phy_address};
    assign cell_len = i_cfg.width8 ? `UCOP_CELL_BYTES8 : `UCOP_CELL_WORDS16;
    // internal clock rises on the edge that sets div; external one is edge-detected
    assign tick = i_cfg.clk_internal ? !q.div : (q.s2.lclk && !q.lclk_p);
    assign match = !i_cfg.level2 || (q.s2.addr == i_cfg.my_addr);

    ucop_cell_buf #(.W(16), .DEPTH(DEPTH), .IDX_W(IDX_W)) u_buf (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_user_word(i_user_word),
        .i_user_valid(i_user_valid),
        .o_user_ready(o_user_ready),
        .i_cell_len(cell_len),
        .o_cell_ready(cell_ready),
        .i_rd_idx(q.idx),
        .o_rd_word(rd_word),
        .i_release(rel)
    );

    always_comb begin
        d = q;
        rel = 1'b0;
        d.s1 = pins;
        d.s2 = q.s1;
        d.lclk_p = q.s2.lclk;
        d.warm = q.warm[1] ? q.warm : q.warm + 2'h1;
        d.div = i_cfg.clk_internal ? ~q.div : 1'b0;
        d.out.lclk = d.div;
        d.out.lclk_oe = i_cfg.clk_internal;
        if (tick) begin
            if (!i_cfg.phy_mode) begin
                d.out.hs_oe = 1'b1;
                case (q.st)
                    ucop_pkg::UCOP_IDLE: begin
                        if (cell_ready && q.s2.hs) begin
                            d.out = put_word(d.out, rd_word, i_cfg.width8, 1'b1);
                            d.out.hs = 1'b0;
                            d.idx = q.idx + 1'b1;
                            d.st = ucop_pkg::UCOP_SEND;
                        end else begin
                            d.out.hs = 1'b1;
                            d.out.soc = 1'b0;
                            d.out.bus_oe = !i_cfg.level2;
                        end
                    end
                    ucop_pkg::UCOP_SEND: begin
                        if (q.idx == cell_len) begin
                            d.out.hs = 1'b1;
                            d.out.soc = 1'b0;
                            d.out.bus_oe = !i_cfg.level2;
                            d.idx = '0;
                            d.st = ucop_pkg::UCOP_IDLE;
                            rel = 1'b1;
                        end else begin
                            d.out = put_word(d.out, rd_word, i_cfg.width8, 1'b0);
                            d.idx = q.idx + 1'b1;
                        end
                    end
                    default: begin
                        d.st = ucop_pkg::UCOP_IDLE;
                    end
                endcase
            end else begin
                d.out.hs = cell_ready && (q.st == ucop_pkg::UCOP_IDLE);
                d.out.hs_oe = match;
                if (q.s2.hs) begin
                    d.sel = match;
                end
                case (q.st)
                    ucop_pkg::UCOP_IDLE: begin
                        if (!q.s2.hs && q.sel && cell_ready) begin
                            d.out = put_word(d.out, rd_word, i_cfg.width8, 1'b1);
                            d.idx = q.idx + 1'b1;
                            d.st = ucop_pkg::UCOP_SEND;
                        end else begin
                            d.out.soc = 1'b0;
                            d.out.bus_oe = !i_cfg.level2;
                        end
                    end
                    ucop_pkg::UCOP_SEND: begin
                        if (q.s2.hs) begin
                            d.out.bus_oe = d.sel || !i_cfg.level2;
                        end else if (q.idx == cell_len) begin
                            d.out.soc = 1'b0;
                            d.out.bus_oe = !i_cfg.level2;
                            d.idx = '0;
                            d.st = ucop_pkg::UCOP_IDLE;
                            rel = 1'b1;
                        end else begin
                            d.out = put_word(d.out, rd_word, i_cfg.width8, 1'b0);
                            d.idx = q.idx + 1'b1;
                        end
                    end
                    default: begin
                        d.st = ucop_pkg::UCOP_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q <= '0;
            q.out.hs <= `UCOP_RST_HS;
            q.out.word <= `UCOP_RST_WORD;
            q.out.par <= ~^`UCOP_RST_WORD;
        end else begin
            q <= d;
        end
    end

    assign o_cell_out_link_clock = q.out.lclk;
    assign o_cell_out_link_clock_oe = q.out.lclk_oe;
    assign o_cell_out_handshake_out = q.out.hs;
    assign o_cell_out_handshake_out_oe = q.out.hs_oe;
    assign o_cell_out_word_bus = q.out.word;
    assign o_cell_out_word_bus_oe = q.out.bus_oe;
    assign o_cell_out_parity = q.out.par;
    assign o_cell_out_parity_oe = q.out.bus_oe;
    assign o_cell_out_start_marker = q.out.soc;
    assign o_cell_out_start_marker_oe = q.out.bus_oe;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    // checks other than a_reset wait two edges after reset so sampled history holds run values
    default disable iff (i_sys_rst || !q.warm[1]);

    sequence s_enb_seen;
        tick && i_cfg.phy_mode && !q.s2.hs && q.sel && q.st == ucop_pkg::UCOP_SEND
            && q.idx != cell_len;
    endsequence
    sequence s_word_moves;
        q.idx == $past(q.idx) + 1'b1 && q.out.soc == 1'b0;
    endsequence

    property p_clk_div;
        i_cfg.clk_internal && $past(i_cfg.clk_internal) |-> o_cell_out_link_clock != $past(o_cell_out_link_clock) && o_cell_out_link_clock_oe;
    endproperty
    a_clk_div: assert property (p_clk_div) else $error("link clock not toggling");

    property p_addr_ignored;
        !i_cfg.phy_mode && tick |=> o_cell_out_handshake_out_oe;
    endproperty
    a_addr_ignored: assert property (p_addr_ignored) else $error("atm enable not driven");

    property p_upper_zero;
        i_cfg.width8 && o_cell_out_word_bus_oe |-> o_cell_out_word_bus[15:8] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper byte active");

    property p_release;
        i_cfg.level2 && tick && q.st == ucop_pkg::UCOP_IDLE && !d.out.soc |=> !o_cell_out_word_bus_oe && !o_cell_out_parity_oe && !o_cell_out_start_marker_oe;
    endproperty
    a_release: assert property (p_release) else $error("bus driven between cells");

    property p_parity;
        o_cell_out_word_bus_oe |-> ^{o_cell_out_parity, o_cell_out_word_bus} == 1'b1;
    endproperty
    a_parity: assert property (p_parity) else $error("parity not odd");

    property p_soc_first;
        o_cell_out_start_marker && o_cell_out_word_bus_oe |-> q.idx == 6'h01;
    endproperty
    a_soc_first: assert property (p_soc_first) else $error("start marker off first word");

    property p_space;
        !i_cfg.phy_mode && $fell(o_cell_out_handshake_out) |-> $past(q.s2.hs) && $past(cell_ready);
    endproperty
    a_space: assert property (p_space) else $error("cell started without space");

    property p_enb_word;
        s_enb_seen |=> s_word_moves;
    endproperty
    a_enb_word: assert property (p_enb_word) else $error("word not advanced on enable");

    property p_enb_valid;
        !i_cfg.phy_mode && !o_cell_out_handshake_out |-> q.st == ucop_pkg::UCOP_SEND && o_cell_out_word_bus_oe;
    endproperty
    a_enb_valid: assert property (p_enb_valid) else $error("enable low without data");

    property p_clav;
        i_cfg.phy_mode && tick |=> o_cell_out_handshake_out == ($past(cell_ready) && $past(q.st) == ucop_pkg::UCOP_IDLE);
    endproperty
    a_clav: assert property (p_clav) else $error("cell available wrong");

    property p_clav_addr;
        i_cfg.phy_mode && i_cfg.level2 && tick |=> o_cell_out_handshake_out_oe == ($past(q.s2.addr) == i_cfg.my_addr);
    endproperty
    a_clav_addr: assert property (p_clav_addr) else $error("handshake driven for other address");

    property p_reset;
        @(posedge i_sys_clk) disable iff (1'b0) $past(i_sys_rst) |-> !o_cell_out_word_bus_oe && !o_cell_out_handshake_out_oe && o_cell_out_handshake_out;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not quiet after reset");
endmodule

//--- testbench/ucop_far_end.sv
// far end model: drives handshake and address, captures sent cells
`timescale 1ns/1ps
module ucop_far_end (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_phy_mode,
    input wire logic i_lclk,
    input wire logic i_space,
    input wire logic i_go,
    input wire logic [4:0] i_addr,
    input wire logic [5:0] i_len,
    input wire ucop_pkg::ucop_out_t i_bus,
    output logic o_hs_in,
    output logic [4:0] o_addr,
    output int o_cnt,
    output int o_bad
);
    logic [17:0] cap [0:63];
    logic busy;
    logic lclk_prev;
    // space only when a whole cell fits; enable low when reading
    assign o_hs_in = i_phy_mode ? !i_go : i_space;
    assign o_addr = i_addr;
    // samples once per link period, one system edge after the link clock rises
    always @(posedge i_sys_clk) begin
        lclk_prev <= i_lclk;
        if (i_sys_rst) begin
            busy <= 1'b0;
            o_cnt <= 0;
            o_bad <= 0;
        end else if (i_lclk && !lclk_prev) begin
            if (busy || (i_bus.bus_oe && i_bus.soc && (i_phy_mode || !i_bus.hs))) begin
                cap[o_cnt] <= {i_bus.soc, i_bus.par, i_bus.word};
                if (!i_bus.bus_oe || (!i_phy_mode && i_bus.hs))
                    o_bad <= o_bad + 1;
                o_cnt <= o_cnt + 1;
                busy <= (o_cnt + 1 < int'(i_len));
            end
        end
    end
endmodule

//--- testbench/ucop_top_tb.sv
// testbench for the cell output port
`timescale 1ns/1ps
`include "ucop_defines.svh"
module ucop_top_tb;
    typedef struct packed {
        logic phy;
        logic l2;
        logic w8;
        logic match;
    } ucop_row_t;
    localparam logic [4:0] MY = 5'h13;
    ucop_row_t rows [0:3] = '{4'h4, 4'h2, 4'hD, 4'hA};
    ucop_row_t r;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    ucop_pkg::ucop_cfg_t cfg = '0;
    logic [15:0] uword = 16'h0000;
    logic uvalid = 1'b0;
    logic ready;
    logic space = 1'b1;
    logic go = 1'b0;
    logic [4:0] far_addr = 5'h00;
    logic ext_clk = 1'b0;
    logic par_oe;
    logic soc_oe;
    logic hs_in;
    logic [4:0] addr;
    logic [5:0] len = 6'h00;
    ucop_pkg::ucop_out_t bus;
    int cnt;
    int bad;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int t;

    ucop_top ucop_top_i (
        .i_sys_clk(sys_clk),
        .i_sys_rst(sys_rst),
        .i_cfg(cfg),
        .i_user_word(uword),
        .i_user_valid(uvalid),
        .o_user_ready(ready),
        .i_cell_out_link_clock(ext_clk),
        .o_cell_out_link_clock(bus.lclk),
        .o_cell_out_link_clock_oe(bus.lclk_oe),
        .i_cell_out_phy_address(addr),
        .i_cell_out_handshake_in(hs_in),
        .o_cell_out_handshake_out(bus.hs),
        .o_cell_out_handshake_out_oe(bus.hs_oe),
        .o_cell_out_word_bus(bus.word),
        .o_cell_out_word_bus_oe(bus.bus_oe),
        .o_cell_out_parity(bus.par),
        .o_cell_out_parity_oe(par_oe),
        .o_cell_out_start_marker(bus.soc),
        .o_cell_out_start_marker_oe(soc_oe)
    );

    ucop_far_end ucop_far_end_i (
        .i_sys_clk(sys_clk),
        .i_sys_rst(sys_rst),
        .i_phy_mode(cfg.phy_mode),
        .i_lclk(cfg.clk_internal ? bus.lclk : ext_clk),
        .i_space(space),
        .i_go(go),
        .i_addr(far_addr),
        .i_len(len),
        .i_bus(bus),
        .o_hs_in(hs_in),
        .o_addr(addr),
        .o_cnt(cnt),
        .o_bad(bad)
    );

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] uw(input int i, input int k);
        return {8'hC0 + k[7:0], 8'h11 + i[7:0]};
    endfunction

    task automatic do_reset(input ucop_pkg::ucop_cfg_t c, input logic [4:0] a, input logic sp);
        logic x;
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        cfg <= c;
        far_addr <= a;
        space <= sp;
        go <= 1'b0;
        len <= c.width8 ? `UCOP_CELL_BYTES8 : `UCOP_CELL_WORDS16;
        repeat (5) @(posedge sys_clk);
        chk({bus.bus_oe, bus.hs_oe, bus.lclk_oe, bus.hs, bus.word}, 20'h10000);
        chk(20'({par_oe, soc_oe}), 20'h0);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(20'(bus.lclk_oe), 20'(c.clk_internal));
        @(negedge sys_clk);
        x = bus.lclk;
        @(negedge sys_clk);
        chk(20'(bus.lclk), 20'(x ^ c.clk_internal));
        @(posedge sys_clk);
    endtask

    task automatic fill(input int k);
        int i;
        for (i = 0; i < int'(len); i++) begin
            uvalid <= 1'b1;
            uword <= uw(i, k);
            @(posedge sys_clk);
        end
        uvalid <= 1'b0;
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 2000 && cnt < int'(len); i++)
            @(posedge sys_clk);
        chk(20'(cnt), 20'(len));
    endtask

    task automatic check_cell(input int k);
        int i;
        logic [15:0] e;
        for (i = 0; i < int'(len); i++) begin
            e = uw(i, k);
            if (cfg.width8)
                e[15:8] = 8'h00;
            chk(20'(ucop_far_end_i.cap[i]), {2'h0, i == 0, ~^e, e});
        end
    endtask

    initial begin
        for (t = 0; t < 4; t++) begin
            r = rows[t];
            do_reset({r.phy, r.l2, r.w8, 1'b1, MY}, r.match ? MY : 5'h0C, 1'b1);
            if (r.phy) begin
                repeat (10) @(posedge sys_clk);
                chk(20'(bus.hs), 20'h0);
            end
            fill(t);
            repeat (10) @(posedge sys_clk);
            chk(20'(ready), 20'h0);
            if (r.phy) begin
                chk(20'({bus.hs, bus.hs_oe}), 20'h3);
                go <= 1'b1;
            end
            wait_done();
            chk(20'(bad), 20'h0);
            check_cell(t);
            repeat (10) @(posedge sys_clk);
            chk(20'({bus.bus_oe, par_oe, soc_oe}), r.l2 ? 20'h0 : 20'h7);
            chk(20'(ready), 20'h1);
            if (!r.phy)
                chk(20'(bus.hs), 20'h1);
            $display("row %0d done", t);
        end
        // far end shows no space until released
        do_reset({1'b0, 1'b1, 1'b0, 1'b1, MY}, MY, 1'b0);
        fill(9);
        repeat (40) @(posedge sys_clk);
        chk({bus.hs, bus.bus_oe, 18'(cnt)}, 20'h80000);
        space <= 1'b1;
        wait_done();
        check_cell(9);
        $display("space test done");
        // another device address is polled; the port stays unselected and off the bus
        do_reset({1'b1, 1'b1, 1'b0, 1'b1, MY}, MY ^ 5'h01, 1'b1);
        fill(5);
        repeat (10) @(posedge sys_clk);
        chk(20'(bus.hs_oe), 20'h0);
        go <= 1'b1;
        repeat (60) @(posedge sys_clk);
        chk({bus.bus_oe, 19'(cnt)}, 20'h0);
        $display("address test done");
        // external link clock: not driven here, cell timed by the far end clock
        do_reset({1'b0, 1'b1, 1'b0, 1'b0, MY}, MY, 1'b1);
        fill(7);
        for (t = 0; t < 200 && cnt < int'(len); t++) begin
            ext_clk <= ~ext_clk;
            repeat (4) @(posedge sys_clk);
        end
        chk(20'(cnt), 20'(len));
        check_cell(7);
        $display("clock test done");
        end_sim();
    end
endmodule
